// ### shared/spms_regs.svh
`ifndef SPMS_REGS_SVH
`define SPMS_REGS_SVH

// Register byte addresses on the bus
`define SPMS_ADR_CTRL   4'h0
`define SPMS_ADR_FLAGS  4'h4
`define SPMS_ADR_DATA   4'h8

// Control field positions
`define SPMS_CTL_SELECT_IGNORE_BIT   7
`define SPMS_CTL_EN     6
`define SPMS_CTL_BIT_ORDER_BIT   5
`define SPMS_CTL_MASTER_SELECT_BIT   4
`define SPMS_CTL_CLOCK_IDLE_LEVEL_BIT   3
`define SPMS_CTL_CLOCK_PHASE_BIT   2
`define SPMS_CTL_SPR_HI 1
`define SPMS_CTL_SPR_LO 0

// Flag field positions
`define SPMS_FLG_DONE   7
`define SPMS_FLG_WRITE_COLLISION_FLAG   6
`define SPMS_FLG_RECEIVE_OVERRUN_FLAG   5
`define SPMS_FLG_MODE_FAULT_FLAG   4

// Reset values
`define SPMS_CTRL_RST   8'h00
`define SPMS_BYTE_RST   8'h00

// Half serial clock periods in system clocks for divide 4, 16, 64, 128
`define SPMS_HALF_DIV4   7'h02
`define SPMS_HALF_DIV16  7'h08
`define SPMS_HALF_DIV64  7'h20
`define SPMS_HALF_DIV128 7'h40

// Serial clock edges in one byte
`define SPMS_EDGES_BYTE 5'h10

`endif

// ### shared/spms_pkg.sv
package spms_pkg;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_MASTER = 2'b01,
    PH_SLAVE  = 2'b10
  } spms_phase_e;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic        transfer_done_flag;
    logic        write_collision_flag;
    logic        receive_overrun_flag;
    logic        mode_fault_flag;
    logic [7:0]  rxbuf;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic        loaded;
    spms_phase_e phase;
    logic [4:0]  edges;
    logic [6:0]  div;
    logic        sck;
    logic        sdo;
    logic        ack;
    logic [7:0]  rdat;
    logic        sck1;
    logic        sck2;
    logic        sck3;
    logic        mosi1;
    logic        mosi2;
    logic        miso1;
    logic        miso2;
    logic        ss1;
    logic        ss2;
  } spms_state_s;

endpackage

// ### rtl/spms_top.sv
// What this block does
// - Data write loads transmitter, read returns received
// - Write while loaded or shifting flags collision
// - Byte done sets flag; overflow keeps old byte
// - Slave select loss, disable or mode fault aborts byte
// - Unloaded slave shifts out all zeros, unless a mode fault left the old byte in the transmitter
// - Slave counts master clock edges to byte
// - Phase zero: select frames each byte, forced
// - Phase one: first edge drives first bit
// - Master select low: fault, drop enable, master
// - Status flags hardware set, write one clears
// - Interrupt is done OR unignored fault
// - Unselected slave floats MISO, selected drives
// - Idle master floats MOSI and SCK unless bit 7 is set
// - Port disabled: pins return to general use
// - Bit 7 chooses select pin or master bit
// - Bit 5 chooses MSB or LSB first
// - Bit 3 sets serial clock idle level
// - Rate field divides clock by 4/16/64/128
// - Low four status bits read zero
`include "spms_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module spms_top (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_o,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe_o,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  input  wire logic        select_n_i,
  output logic             irq_o
);

  spms_pkg::spms_state_s q;
  spms_pkg::spms_state_s d;

  logic       en;
  logic       select_ignore_bit;
  logic       clock_phase_bit;
  logic       bit_order_bit;
  logic       is_master;
  logic       slave_sel;
  logic       req;
  logic       wr;
  logic       wr_ctrl;
  logic       wr_flags;
  logic       wr_data;
  logic       edge_ev;
  logic       done;
  logic       fault;
  logic [4:0] edges_n;
  logic [6:0] half;
  logic [7:0] rx_n;
  logic [2:0] k;
  logic       smp;
  logic       smp_bit;

  assign en        = q.ctrl[`SPMS_CTL_EN];
  assign select_ignore_bit      = q.ctrl[`SPMS_CTL_SELECT_IGNORE_BIT];
  assign clock_phase_bit      = q.ctrl[`SPMS_CTL_CLOCK_PHASE_BIT];
  assign bit_order_bit      = q.ctrl[`SPMS_CTL_BIT_ORDER_BIT];
  assign is_master = en & q.ctrl[`SPMS_CTL_MASTER_SELECT_BIT];
  // Phase zero ignores the select-ignore bit: pin always frames the byte
  assign slave_sel = en & ~q.ctrl[`SPMS_CTL_MASTER_SELECT_BIT] & ((select_ignore_bit & clock_phase_bit) | ~q.ss2);
  assign req       = wb_cyc_i & wb_stb_i;
  // Writes land on the edge that the master sees ack
  assign wr        = req & wb_we_i & q.ack & wb_sel_i[0];
  assign wr_ctrl   = wr & (wb_adr_i == `SPMS_ADR_CTRL);
  assign wr_flags  = wr & (wb_adr_i == `SPMS_ADR_FLAGS);
  assign wr_data   = wr & (wb_adr_i == `SPMS_ADR_DATA);
  assign fault     = is_master & ~select_ignore_bit & ~q.ss2;

  always_comb begin
    case (q.ctrl[`SPMS_CTL_SPR_HI:`SPMS_CTL_SPR_LO])
      2'b00:   half = `SPMS_HALF_DIV4;
      2'b01:   half = `SPMS_HALF_DIV16;
      2'b10:   half = `SPMS_HALF_DIV64;
      default: half = `SPMS_HALF_DIV128;
    endcase
  end

  always_comb begin
    d = q;
    d.ack   = req & ~q.ack;
    d.sck1  = sck_i;
    d.sck2  = q.sck1;
    d.sck3  = q.sck2;
    d.mosi1 = mosi_i;
    d.mosi2 = q.mosi1;
    d.miso1 = miso_i;
    d.miso2 = q.miso1;
    d.ss1   = select_n_i;
    d.ss2   = q.ss1;
    done    = 1'b0;
    edge_ev = 1'b0;
    smp     = 1'b0;
    smp_bit = 1'b0;
    edges_n = q.edges + 5'h01;
    rx_n    = q.rx;

    if (req & ~q.ack) begin
      case (wb_adr_i)
        `SPMS_ADR_CTRL:  d.rdat = q.ctrl;
        `SPMS_ADR_FLAGS: d.rdat = {q.transfer_done_flag, q.write_collision_flag, q.receive_overrun_flag, q.mode_fault_flag, 4'h0};
        `SPMS_ADR_DATA:  d.rdat = q.rxbuf;
        default:         d.rdat = 8'h00;
      endcase
    end

    if (wr_ctrl) begin
      d.ctrl = wb_dat_i[7:0];
      // Enable stays off while a fault is pending
      d.ctrl[`SPMS_CTL_EN] = wb_dat_i[`SPMS_CTL_EN] & ~q.mode_fault_flag;
    end

    if (wr_flags) begin
      d.transfer_done_flag = q.transfer_done_flag & ~wb_dat_i[`SPMS_FLG_DONE];
      d.write_collision_flag = q.write_collision_flag & ~wb_dat_i[`SPMS_FLG_WRITE_COLLISION_FLAG];
      d.receive_overrun_flag = q.receive_overrun_flag & ~wb_dat_i[`SPMS_FLG_RECEIVE_OVERRUN_FLAG];
      d.mode_fault_flag = q.mode_fault_flag & ~wb_dat_i[`SPMS_FLG_MODE_FAULT_FLAG];
    end

    if (wr_data) begin
      if (q.loaded || q.phase != spms_pkg::PH_IDLE || q.edges != 5'h00) begin
        d.write_collision_flag = 1'b1;
      end else begin
        d.tx     = wb_dat_i[7:0];
        d.loaded = 1'b1;
        if (is_master && !fault) begin
          d.phase = spms_pkg::PH_MASTER;
          d.edges = 5'h00;
          d.div   = half;
        end
      end
    end

    // Serial clock events from own divider or from the synchronised pin
    if (q.phase == spms_pkg::PH_MASTER) begin
      if (q.div == 7'h01) begin
        d.div   = half;
        d.sck   = ~q.sck;
        edge_ev = 1'b1;
      end else begin
        d.div = q.div - 7'h01;
      end
    end else if (slave_sel && (q.sck2 ^ q.sck3)) begin
      edge_ev = 1'b1;
      d.phase = spms_pkg::PH_SLAVE;
    end

    if (edge_ev) begin
      d.edges = edges_n;
      if (edges_n == `SPMS_EDGES_BYTE && q.phase != spms_pkg::PH_MASTER) begin
        done = 1'b1;
      end
    end

    // Phase zero samples odd edges, phase one even edges
    // Master takes its bit one clock late: the pin synchroniser lags
    // a full half period at divide 4, so the edge would see a stale bit
    if (q.phase == spms_pkg::PH_MASTER) begin
      smp     = (q.edges != 5'h00) && (q.div == half) && (q.edges[0] ^ clock_phase_bit);
      smp_bit = q.miso2;
      done    = (q.edges == `SPMS_EDGES_BYTE);
    end else begin
      smp     = edge_ev && (edges_n[0] ^ clock_phase_bit);
      smp_bit = q.mosi2;
    end

    if (smp) begin
      if (bit_order_bit) begin
        rx_n = {smp_bit, q.rx[7:1]};
      end else begin
        rx_n = {q.rx[6:0], smp_bit};
      end
      d.rx = rx_n;
    end

    if (done) begin
      d.phase  = spms_pkg::PH_IDLE;
      d.edges  = 5'h00;
      d.loaded = 1'b0;
      d.tx     = `SPMS_BYTE_RST;
      d.transfer_done_flag   = 1'b1;
      if (q.transfer_done_flag) begin
        d.receive_overrun_flag = 1'b1;
      end else begin
        d.rxbuf = rx_n;
      end
    end

    // Losing selection mid byte drops it without a done flag
    if (!is_master && !slave_sel && (q.edges != 5'h00 || q.phase != spms_pkg::PH_IDLE)) begin
      d.phase = spms_pkg::PH_IDLE;
      d.edges = 5'h00;
    end

    if (fault) begin
      d.mode_fault_flag                 = 1'b1;
      d.ctrl[`SPMS_CTL_EN]   = 1'b0;
      d.ctrl[`SPMS_CTL_MASTER_SELECT_BIT] = 1'b0;
      d.phase                = spms_pkg::PH_IDLE;
      d.edges                = 5'h00;
      d.loaded               = 1'b0;
    end

    if (!en) begin
      d.phase = spms_pkg::PH_IDLE;
      d.edges = 5'h00;
    end

    if (d.phase != spms_pkg::PH_MASTER) begin
      d.sck = d.ctrl[`SPMS_CTL_CLOCK_IDLE_LEVEL_BIT];
    end

    // Registered serial out bit, index advances on each shift edge
    if (d.ctrl[`SPMS_CTL_CLOCK_PHASE_BIT]) begin
      k = (d.edges == 5'h00) ? 3'h0 : 3'((d.edges - 5'h01) >> 1);
    end else begin
      k = 3'(d.edges >> 1);
    end
    d.sdo = d.ctrl[`SPMS_CTL_BIT_ORDER_BIT] ? d.tx[k] : d.tx[3'h7 - k];
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      q       <= '0;
      q.ctrl  <= `SPMS_CTRL_RST;
      q.phase <= spms_pkg::PH_IDLE;
      q.ss1   <= 1'b1;
      q.ss2   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o  = {24'h00_0000, q.rdat};
  assign wb_ack_o  = q.ack;
  assign sck_o     = q.sck;
  // Idle master floats unless the select pin is ignored
  assign sck_oe_o  = is_master & ((q.phase == spms_pkg::PH_MASTER) | select_ignore_bit);
  assign mosi_o    = q.sdo;
  assign mosi_oe_o = sck_oe_o;
  assign miso_o    = q.sdo;
  assign miso_oe_o = slave_sel;
  assign irq_o     = q.transfer_done_flag | (q.mode_fault_flag & ~select_ignore_bit);

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence s_fault_seen;
    is_master && !select_ignore_bit && !q.ss2;
  endsequence

  sequence s_fault_taken;
    q.mode_fault_flag && !q.ctrl[`SPMS_CTL_EN] && !q.ctrl[`SPMS_CTL_MASTER_SELECT_BIT] && q.phase == spms_pkg::PH_IDLE;
  endsequence

  a_fault_drops_port: assert property (s_fault_seen |=> s_fault_taken)
    else $error("mode fault did not disable the port");

  a_collision_keeps: assert property (
    (wr_data && q.phase == spms_pkg::PH_MASTER && !done) |=> (q.write_collision_flag && $stable(q.tx)))
    else $error("collision corrupted the byte in progress");

  a_overflow_keeps: assert property (
    (done && q.transfer_done_flag) |=> (q.receive_overrun_flag && q.transfer_done_flag && $stable(q.rxbuf)))
    else $error("overflow stored a late byte");

  a_done_sets_flag: assert property (
    (edge_ev && q.edges == 5'h0f && q.phase == spms_pkg::PH_SLAVE) |=> (q.transfer_done_flag && q.edges == 5'h00))
    else $error("byte end did not set the done flag");

  a_master_done: assert property (
    (q.phase == spms_pkg::PH_MASTER && q.edges == `SPMS_EDGES_BYTE && !wr_ctrl)
      |=> (q.transfer_done_flag && q.phase == spms_pkg::PH_IDLE && sck_o == q.ctrl[`SPMS_CTL_CLOCK_IDLE_LEVEL_BIT]))
    else $error("master byte end did not finish cleanly");

  a_flag_clear: assert property (
    (wr_flags && wb_dat_i[`SPMS_FLG_WRITE_COLLISION_FLAG] && !wr_data) |=> !q.write_collision_flag)
    else $error("write one did not clear collision flag");

  a_reserved_zero: assert property (
    (req && !q.ack && wb_adr_i == `SPMS_ADR_FLAGS) |=> (wb_ack_o && wb_dat_o[3:0] == 4'h0))
    else $error("reserved status bits not zero");

  a_idle_clock: assert property (
    (q.phase == spms_pkg::PH_IDLE && $stable(q.ctrl))[*2] |-> sck_o == q.ctrl[`SPMS_CTL_CLOCK_IDLE_LEVEL_BIT])
    else $error("serial clock not at idle level");

  a_disabled_pins: assert property (
    (!en && $past(!en)) |-> (!sck_oe_o && !mosi_oe_o && !miso_oe_o && q.phase == spms_pkg::PH_IDLE))
    else $error("disabled port still drives pins");

  a_master_start: assert property (
    (wr_data && is_master && !fault && !q.loaded && q.phase == spms_pkg::PH_IDLE && q.edges == 5'h00)
      |=> (q.phase == spms_pkg::PH_MASTER && q.edges == 5'h00 && sck_oe_o))
    else $error("master write did not start a transfer");

  a_abort_no_flag: assert property (
    (q.phase == spms_pkg::PH_SLAVE && !slave_sel && !q.transfer_done_flag && !(wr_flags)) |=> (!q.transfer_done_flag && q.edges == 5'h00))
    else $error("aborted slave byte set done flag");

endmodule

`default_nettype wire

// ### tb/spms_peer.sv
`timescale 1ns/1ps
`default_nettype none

module spms_peer (
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       clock_phase_bit_i,
  input  wire logic       lsb_i,
  input  wire logic       arm_i,
  input  wire logic [7:0] tx_i,
  output logic            miso_o,
  output var logic  [7:0] rx_o,
  output var int          edges_o
);
  logic [7:0] sr;

  // Any toggle reloads, so the bench needs no pulse timing
  always @(arm_i) begin
    sr = tx_i;
    edges_o = 0;
  end

  always @(sck_i) begin
    edges_o = edges_o + 1;
    if (edges_o[0] != clock_phase_bit_i) begin
      rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
    end else if (edges_o > 1) begin
      sr = lsb_i ? sr >> 1 : sr << 1;
    end
  end

  // First bit sits on the line before the first edge
  assign miso_o = lsb_i ? sr[0] : sr[7];
endmodule

`default_nettype wire

// ### tb/spms_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

module spms_top_bench;
  logic        clock_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [3:0]  wb_adr = 4'h0;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        sck_o;
  logic        sck_oe_o;
  logic        mosi_o;
  logic        mosi_oe_o;
  logic        miso;
  logic        miso_o;
  logic        miso_oe_o;
  logic        select_n = 1'b1;
  logic        irq_o;
  logic        arm = 1'b0;
  logic [7:0]  ptx = 8'h00;
  logic [7:0]  prx;
  int          pedges;
  logic [7:0]  ctl = 8'h00;
  logic [7:0]  txb;
  logic [7:0]  rxb;
  logic [7:0]  last = 8'h00;
  logic        keep = 1'b0;
  int          h;
  logic [31:0] exp_q[$];
  int          n_mismatch = 0;
  int          check_count = 0;

  spms_top dut (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .wb_cyc_i  (wb_cyc),
    .wb_stb_i  (wb_stb),
    .wb_we_i   (wb_we),
    .wb_adr_i  (wb_adr),
    .wb_sel_i  (4'hf),
    .wb_dat_i  (wb_dat),
    .wb_dat_o  (wb_dat_o),
    .wb_ack_o  (wb_ack_o),
    .sck_i     (1'b0),
    .sck_o     (sck_o),
    .sck_oe_o  (sck_oe_o),
    .mosi_i    (1'b0),
    .mosi_o    (mosi_o),
    .mosi_oe_o (mosi_oe_o),
    .miso_i    (miso_oe_o ? miso_o : miso),
    .miso_o    (miso_o),
    .miso_oe_o (miso_oe_o),
    .select_n_i(select_n),
    .irq_o     (irq_o)
  );

  spms_peer peer (
    .sck_i  (sck_o),
    .mosi_i (mosi_o),
    .clock_phase_bit_i (ctl[2]),
    .lsb_i  (ctl[5]),
    .arm_i  (arm),
    .tx_i   (ptx),
    .miso_o (miso),
    .rx_o   (prx),
    .edges_o(pedges)
  );

  initial begin
    forever #50 clock_i = ~clock_i;
  end

  task automatic stop_test;
    $display("Mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chkw(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t read %h expected %h", $time, g, e);
    end
  endtask

  task automatic chkb(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask

  // Request held until ack is seen, so the slave sets the pace
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= {24'h00_0000, d};
    do @(posedge clock_i); while (wb_ack_o !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back({24'h00_0000, e});
    bus(1'b0, a, 8'h00);
  endtask

  always @(posedge clock_i) begin
    if (wb_ack_o === 1'b1 && wb_we === 1'b0) begin
      chkw(wb_dat_o, exp_q.pop_front());
    end
  end

  initial begin
    repeat (10000) @(posedge clock_i);
    n_mismatch++;
    stop_test();
  end

  initial begin
    void'($urandom(56257));
    repeat (4) @(posedge clock_i);
    reset_i <= 1'b0;
    chkb(8'(sck_oe_o), 8'h00);
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'h00);
    rd(4'hc, 8'h00);
    wr(4'h4, 8'h0f);
    rd(4'h4, 8'h00);
    for (int m = 0; m < 8; m++) begin
      ctl = {2'b11, m[2], 1'b1, m[0], m[1], m[1:0]};
      wr(4'h0, ctl);
      h = (m[1:0] == 2'b11) ? 64 : 2 << (2 * m[1:0]);
      txb = 8'($urandom);
      rxb = 8'($urandom);
      ptx <= rxb;
      repeat (4) @(posedge clock_i);
      arm <= ~arm;
      wr(4'h8, txb);
      repeat (16 * h - 10) @(posedge clock_i);
      rd(4'h4, keep ? 8'h80 : 8'h00);
      chkb(8'(mosi_oe_o), 8'h01);
      wr(4'h8, ~txb);
      repeat (12) @(posedge clock_i);
      rd(4'h4, keep ? 8'he0 : 8'hc0);
      rd(4'h8, keep ? last : rxb);
      chkb(prx, txb);
      chkb(8'(pedges), 8'h10);
      chkb(8'(sck_o), 8'(ctl[3]));
      chkb(8'(irq_o), 8'h01);
      if (!keep) begin
        last = rxb;
      end
      keep = !m[0];
      // Clearing only the collision leaves done up for an overrun next time
      wr(4'h4, keep ? 8'h40 : 8'hf0);
    end
    wr(4'h0, 8'h50);
    select_n <= 1'b0;
    repeat (6) @(posedge clock_i);
    rd(4'h4, 8'h10);
    rd(4'h0, 8'h00);
    chkb(8'(irq_o), 8'h01);
    chkb(8'(sck_oe_o), 8'h00);
    wr(4'h0, 8'h40);
    rd(4'h0, 8'h00);
    wr(4'h4, 8'h10);
    select_n <= 1'b1;
    wr(4'h0, 8'h40);
    rd(4'h0, 8'h40);
    chkb(8'(irq_o), 8'h00);
    stop_test();
  end
endmodule

`default_nettype wire
